// ===== core/event_terminal_mux.sv
`default_nettype none
module event_terminal_mux
    import gen_event_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic pending_in,
    input wire logic [TERMINAL_COUNT-1:0] route_in,
    output logic [TERMINAL_COUNT-1:0] term_out,
    output logic [TERMINAL_COUNT-1:0] term_oe_out
);

    // ------------------------------------------------------------
    // Registered terminal drivers for the active-low event line
    // ------------------------------------------------------------
    // Unrouted terminals stay undriven and idle high
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            term_out <= {TERMINAL_COUNT{1'b1}};
            term_oe_out <= {TERMINAL_COUNT{1'b0}};
        end else begin
            term_out <= ~({TERMINAL_COUNT{pending_in}} & route_in);
            term_oe_out <= route_in;
        end
    end

endmodule : event_terminal_mux
`default_nettype wire

// ===== core/gen_event_pkg.sv
`default_nettype none
package gen_event_pkg;

    // ------------------------------------------------------------
    // Configuration space offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] PM_DATA_OFFSET = 8'hA7;
    localparam logic [7:0] EVENT_STATUS_OFFSET = 8'hA8;
    localparam logic [7:0] EVENT_ENABLE_OFFSET = 8'hAA;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] PM_DATA_RESET = 8'h00;
    localparam logic [15:0] EVENT_STATUS_RESET = 16'h0000;
    localparam logic [15:0] EVENT_ENABLE_RESET = 16'h0000;

    // ------------------------------------------------------------
    // Field positions inside status and enable
    // ------------------------------------------------------------
    localparam int SOCKET0_VIDEO_BIT = 15;
    localparam int SOCKET1_VIDEO_BIT = 14;
    localparam int SOCKET_POWER_BIT = 11;
    localparam int PROG_VOLTAGE_BIT = 8;
    localparam int INPUT_LSB = 0;
    localparam int INPUT_COUNT = 5;
    localparam int TERMINAL_COUNT = 7;
    // Implemented bits; 13-12, 10-9 and 7-5 are reserved_bits
    localparam logic [15:0] EVENT_BITS_MASK = 16'hC91F;

    // Function number that owns the event registers
    localparam logic FUNC_OWNER = 1'b0;

    // Programming voltage request code meaning 12 V
    localparam logic [1:0] VPP_12V_CODE = 2'h2;

    // Cycles after reset release before change detection is armed
    localparam logic [1:0] ARM_COUNT = 2'h3;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic write;
        logic func;
        logic [5:0] dword_addr;
        logic [3:0] byte_en;
        logic [31:0] wdata;
    } cfg_req_t;

    typedef struct packed {
        logic [1:0] vcc_req;
        logic [1:0] vpp_req;
    } power_setting_t;

endpackage : gen_event_pkg
`default_nettype wire

// ===== core/general_purpose_event_logic.sv
`default_nettype none
module general_purpose_event_logic
    import gen_event_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Configuration access
    input wire cfg_req_t cfg_req_in,
    output logic cfg_ack_out,
    output logic [31:0] cfg_rdata_out,
    // Event sources from the socket controllers
    input wire logic [1:0] video_port_on_flag_in,
    input wire power_setting_t socket0_power_in,
    input wire power_setting_t socket1_power_in,
    // Multipurpose terminal inputs and configuration
    input wire logic [INPUT_COUNT-1:0] general_input_in,
    input wire logic [INPUT_COUNT-1:0] input_mode_in,
    input wire logic [TERMINAL_COUNT-1:0] event_route_in,
    // Terminal drivers carrying general_event_out_n
    output logic [TERMINAL_COUNT-1:0] multipurpose_terminals_out,
    output logic [TERMINAL_COUNT-1:0] multipurpose_terminals_oe_out,
    // Status mirror
    output logic [15:0] event_status_out
);

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    // True when the access hits the dword that holds the given byte
    function automatic logic dword_hit(input logic [5:0] dword_addr, input logic [7:0] byte_offset);
        dword_hit = (dword_addr == byte_offset[7:2]);
    endfunction : dword_hit

    // Spread byte enables of a 16-bit half into a bit mask
    // Lanes that are off leave their bits untouched on writes
    function automatic logic [15:0] half_mask(input logic [1:0] be);
        half_mask = {{8{be[1]}}, {8{be[0]}}};
    endfunction : half_mask

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    // Status and enable keep only implemented bits; the mask is applied
    // on every path so reserved bits can never be stored
    logic [15:0] event_status_q;
    logic [15:0] event_status_d;
    logic [15:0] event_enable_q;
    logic [15:0] event_set;
    logic [15:0] status_clear;
    logic [15:0] gated_enable;
    logic [1:0] video_prev_q;
    power_setting_t socket0_prev_q;
    power_setting_t socket1_prev_q;
    logic sources_armed_q;
    logic [INPUT_COUNT-1:0] input_change;
    logic [1:0] video_change;
    logic enable_hit;
    logic [15:0] enable_wmask;
    logic [15:0] event_contrib;
    logic read_req;
    logic pm_data_hit;
    logic event_regs_hit;
    logic [15:0] status_rdata;
    logic [15:0] enable_rdata;
    logic power_change;
    logic vpp12_change;
    logic owner_write;
    logic status_hit;
    logic pending;
    logic [31:0] rdata_d;

    // ------------------------------------------------------------
    // Terminal input change detection
    // ------------------------------------------------------------
    // synchronise terminal inputs
    // Detection is held off until the synchroniser has filled, so a pin
    // strapped high at reset does not look like a change
    // Only the change pulses are used here; the synchronised levels
    // belong to the input data register, which sits outside this block
    input_change_detect u_detect (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .pins_in(general_input_in),
        .level_out(),
        .change_out(input_change)
    );

    // ------------------------------------------------------------
    // Same-clock source history
    // ------------------------------------------------------------
    // These sources come from socket logic on this clock, so they skip
    // the synchroniser; a change reaches status at the next edge
    // Previous values of flags and power settings; the first cycle after
    // reset only loads history so a strapped level is not seen as a change
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            video_prev_q <= 2'h0;
            socket0_prev_q <= '0;
            socket1_prev_q <= '0;
            sources_armed_q <= 1'b0;
        end else begin
            video_prev_q <= video_port_on_flag_in;
            socket0_prev_q <= socket0_power_in;
            socket1_prev_q <= socket1_power_in;
            sources_armed_q <= 1'b1;
        end
    end

    // either edge of each socket's video flag
    assign video_change = video_port_on_flag_in ^ video_prev_q;

    // Supply and programming requests count alike for the power bit
    // any supply or programming voltage change
    assign power_change = (socket0_power_in != socket0_prev_q) | (socket1_power_in != socket1_prev_q);

    // crossing into or out of 12 V
    assign vpp12_change =
        ((socket0_power_in.vpp_req == VPP_12V_CODE) != (socket0_prev_q.vpp_req == VPP_12V_CODE)) |
        ((socket1_power_in.vpp_req == VPP_12V_CODE) != (socket1_prev_q.vpp_req == VPP_12V_CODE));

    // ------------------------------------------------------------
    // Event set vector
    // ------------------------------------------------------------
    // Same-clock sources wait one edge after reset; terminal inputs wait
    // for the synchroniser to fill inside the detector
    always_comb begin
        event_set = 16'h0000;
        if (sources_armed_q) begin
            event_set[SOCKET0_VIDEO_BIT] = video_change[0];
            event_set[SOCKET1_VIDEO_BIT] = video_change[1];
            event_set[SOCKET_POWER_BIT] = power_change;
            event_set[PROG_VOLTAGE_BIT] = vpp12_change;
        end
        // terminal level changes, bits 4 to 0
        event_set[INPUT_LSB +: INPUT_COUNT] = input_change;
    end

    // ------------------------------------------------------------
    // Configuration write decode
    // ------------------------------------------------------------
    // A write to function 1 reaches neither register; its decode is
    // dropped here once rather than at every register
    // only function 0 owns status and enable
    assign owner_write = cfg_req_in.valid & cfg_req_in.write & (cfg_req_in.func == FUNC_OWNER);
    assign status_hit = owner_write & dword_hit(cfg_req_in.dword_addr, EVENT_STATUS_OFFSET);

    assign status_clear = status_hit ? (cfg_req_in.wdata[15:0] & half_mask(cfg_req_in.byte_en[1:0])) : 16'h0000;

    // ------------------------------------------------------------
    // Status register
    // ------------------------------------------------------------
    // A set in the same cycle as a clear wins, so no event is lost
    // Software must re-read after clearing: an event that lands in the
    // clearing cycle leaves its bit set
    always_comb begin
        // set does not look at the enable
        event_status_d = ((event_status_q & ~status_clear) | event_set) & EVENT_BITS_MASK;
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            event_status_q <= EVENT_STATUS_RESET;
        end else begin
            event_status_q <= event_status_d;
        end
    end

    // ------------------------------------------------------------
    // Enable register
    // ------------------------------------------------------------
    // Enable sits in the upper half of the same dword as status, so
    // one write may clear status and load enable together
    assign enable_hit = owner_write & dword_hit(cfg_req_in.dword_addr, EVENT_ENABLE_OFFSET);
    assign enable_wmask = half_mask(cfg_req_in.byte_en[3:2]);

    // function 0 only, writable bits masked
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            event_enable_q <= EVENT_ENABLE_RESET;
        end else if (enable_hit) begin
            event_enable_q <= ((cfg_req_in.wdata[31:16] & enable_wmask) |
                               (event_enable_q & ~enable_wmask)) & EVENT_BITS_MASK;
        end
    end

    // ------------------------------------------------------------
    // Event output
    // ------------------------------------------------------------
    // Input events count only while their terminal is an input; the
    // status bit still latches so software can see it after a mode change
    always_comb begin
        gated_enable = event_enable_q;
        gated_enable[INPUT_LSB +: INPUT_COUNT] = event_enable_q[INPUT_LSB +: INPUT_COUNT] & input_mode_in;
    end

    // per-bit gating of status
    // Reserved bits have no enable storage, so their slots stay zero
    genvar bit_idx;
    generate
        for (bit_idx = 0; bit_idx < 16; bit_idx++) begin : g_contrib
            assign event_contrib[bit_idx] = event_status_q[bit_idx] & gated_enable[bit_idx];
        end
    endgenerate

    // any enabled status bit asserts the output
    // holds while the status bit stays set; another enabled
    // bit keeps it low even after one bit is cleared
    assign pending = |event_contrib;

    // The terminal stage adds one register so the pins come straight
    // from flip-flops; the pins follow status one edge later
    // drive only terminals routed for the event
    event_terminal_mux u_mux (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .pending_in(pending),
        .route_in(event_route_in),
        .term_out(multipurpose_terminals_out),
        .term_oe_out(multipurpose_terminals_oe_out)
    );

    // ------------------------------------------------------------
    // Configuration read path
    // ------------------------------------------------------------
    // Read decode; the data byte answers both functions
    assign read_req = cfg_req_in.valid & ~cfg_req_in.write;
    assign pm_data_hit = dword_hit(cfg_req_in.dword_addr, PM_DATA_OFFSET);
    // event registers answer function 0 only
    assign event_regs_hit = dword_hit(cfg_req_in.dword_addr, EVENT_STATUS_OFFSET) &
                            (cfg_req_in.func == FUNC_OWNER);

    // reserved bits read zero in both halves
    assign status_rdata = event_status_q & EVENT_BITS_MASK & half_mask(cfg_req_in.byte_en[1:0]);
    assign enable_rdata = event_enable_q & EVENT_BITS_MASK & half_mask(cfg_req_in.byte_en[3:2]);

    // Unowned offsets and function 1 read as zero; byte lanes not
    // enabled also return zero so the mux stays simple
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (read_req) begin
            if (pm_data_hit) begin
                // data byte always zero, both functions
                rdata_d[31:24] = PM_DATA_RESET;
            end else if (event_regs_hit) begin
                rdata_d = {enable_rdata, status_rdata};
            end
        end
    end

    // One-cycle acknowledge for every request, reads and writes alike
    // Writes return zero data; the host only takes it on reads
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            cfg_ack_out <= 1'b0;
            cfg_rdata_out <= 32'h0000_0000;
        end else begin
            cfg_ack_out <= cfg_req_in.valid;
            cfg_rdata_out <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // Status mirror output
    // ------------------------------------------------------------
    // Registered copy keeps the output straight from a flip-flop
    // It loads the next state so it lines up with the status register
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            event_status_out <= EVENT_STATUS_RESET;
        end else begin
            event_status_out <= event_status_d;
        end
    end

endmodule : general_purpose_event_logic
`default_nettype wire

// ===== core/input_change_detect.sv
`default_nettype none
module input_change_detect
    import gen_event_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [INPUT_COUNT-1:0] pins_in,
    output logic [INPUT_COUNT-1:0] level_out,
    output logic [INPUT_COUNT-1:0] change_out
);

    // ------------------------------------------------------------
    // Two-stage synchroniser and edge detect per input
    // ------------------------------------------------------------
    logic [1:0] arm_cnt_q;
    logic armed;

    // Hold off detection until the synchroniser holds real pin data
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            arm_cnt_q <= 2'h0;
        end else if (arm_cnt_q != ARM_COUNT) begin
            arm_cnt_q <= arm_cnt_q + 2'h1;
        end
    end

    assign armed = (arm_cnt_q == ARM_COUNT);

    genvar i;
    generate
        for (i = 0; i < INPUT_COUNT; i++) begin : g_input
            logic meta_q;
            logic sync_q;
            logic prev_q;

            always_ff @(posedge clk_in) begin
                if (!rst_b_in) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                    prev_q <= 1'b0;
                end else begin
                    meta_q <= pins_in[i];
                    sync_q <= meta_q;
                    prev_q <= sync_q;
                end
            end

            assign level_out[i] = sync_q;
            // Either edge counts as a change
            assign change_out[i] = armed & (sync_q ^ prev_q);
        end
    endgenerate

endmodule : input_change_detect
`default_nettype wire

// ===== testbench/event_receiver.sv
`default_nettype none
module event_receiver
    import gen_event_pkg::*;
(
    input wire logic [TERMINAL_COUNT-1:0] terminals_in,
    input wire logic [TERMINAL_COUNT-1:0] terminals_oe_in,
    output logic event_seen_out
);
    // Pulled-up pins: an undriven terminal reads high
    logic [TERMINAL_COUNT-1:0] level;
    assign level = terminals_in | ~terminals_oe_in;
    assign event_seen_out = ~&level;
endmodule : event_receiver
`default_nettype wire

// ===== testbench/gen_event_asserts.sv
`default_nettype none
module gen_event_asserts
    import gen_event_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire cfg_req_t cfg_req_in,
    input wire logic cfg_ack_out,
    input wire logic [31:0] cfg_rdata_out,
    input wire logic [1:0] video_port_on_flag_in,
    input wire power_setting_t socket0_power_in,
    input wire power_setting_t socket1_power_in,
    input wire logic [INPUT_COUNT-1:0] general_input_in,
    input wire logic [TERMINAL_COUNT-1:0] multipurpose_terminals_out,
    input wire logic [TERMINAL_COUNT-1:0] multipurpose_terminals_oe_out,
    input wire logic [15:0] event_status_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    // Edges since release; the first edge only loads history
    logic [1:0] up_q;
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            up_q <= 2'h0;
        end else if (up_q != 2'h3) begin
            up_q <= up_q + 2'h1;
        end
    end

    // Clearing write and 12 V request decode
    logic clr_wr;
    logic [1:0] vpp12;
    assign clr_wr = cfg_req_in.valid && cfg_req_in.write && !cfg_req_in.func && cfg_req_in.dword_addr == 6'h2A;
    assign vpp12 = {socket1_power_in.vpp_req == VPP_12V_CODE, socket0_power_in.vpp_req == VPP_12V_CODE};

    sequence pm_read_s;
        cfg_req_in.valid && !cfg_req_in.write && cfg_req_in.dword_addr == 6'h29;
    endsequence

    AST_ACK: assert property (cfg_req_in.valid |=> cfg_ack_out) else $error("ack missing");
    AST_NO_ACK: assert property (!cfg_req_in.valid |=> !cfg_ack_out) else $error("stray ack");
    AST_PM_ZERO: assert property (pm_read_s |=> cfg_rdata_out == 32'h0) else $error("data reg nonzero");
    AST_RESERVED_BITS: assert property ((event_status_out & ~EVENT_BITS_MASK) == 16'h0) else $error("reserved set");
    AST_VID0: assert property (up_q != 2'h0 && $changed(video_port_on_flag_in[0])
        |=> event_status_out[15]) else $error("bit 15 not set");
    AST_VID1: assert property (up_q != 2'h0 && $changed(video_port_on_flag_in[1])
        |=> event_status_out[14]) else $error("bit 14 not set");
    AST_PWR: assert property (up_q != 2'h0 && $changed({socket0_power_in, socket1_power_in})
        |=> event_status_out[11]) else $error("bit 11 not set");
    AST_VPP: assert property (up_q != 2'h0 && $changed(vpp12) |=> event_status_out[8]) else $error("bit 8 not set");
    AST_GPI: assert property (up_q == 2'h3 && $changed(general_input_in[4])
        |-> ##[1:4] event_status_out[4]) else $error("bit 4 not set");
    AST_STICKY: assert property (up_q != 2'h0 && |($past(event_status_out) & ~event_status_out)
        |-> $past(clr_wr)) else $error("status fell unasked");
    AST_UNROUTED: assert property ((~multipurpose_terminals_out & ~multipurpose_terminals_oe_out) == 7'h00)
        else $error("undriven pin low");
    AST_CAUSE: assert property (|(~multipurpose_terminals_out) |-> $past(|event_status_out))
        else $error("event without status");
endmodule : gen_event_asserts
`default_nettype wire

// ===== testbench/general_purpose_event_logic_tb_top.sv
`default_nettype none
module general_purpose_event_logic_tb_top import gen_event_pkg::*; ();
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    cfg_req_t req = '0;
    logic ack;
    logic [31:0] rdata;
    logic [1:0] vid = 2'h0;
    power_setting_t pw0 = '0;
    power_setting_t pw1 = '0;
    logic [4:0] gin = '0;
    logic [4:0] mode = '1;
    logic [6:0] route = 7'h01;
    logic [6:0] term;
    logic [6:0] oe;
    logic [15:0] sts;
    logic ev;
    int errors = 0;
    int checked = 0;
    int seed = 34827;
    logic [31:0] exp_q[$];
    logic [15:0] en_m = '0;

    initial begin
        forever #12.5 clk_in = ~clk_in;
    end

    general_purpose_event_logic dut_u (.clk_in, .rst_b_in, .cfg_req_in(req), .cfg_ack_out(ack),
        .cfg_rdata_out(rdata), .video_port_on_flag_in(vid), .socket0_power_in(pw0), .socket1_power_in(pw1),
        .general_input_in(gin), .input_mode_in(mode), .event_route_in(route),
        .multipurpose_terminals_out(term), .multipurpose_terminals_oe_out(oe), .event_status_out(sts));
    event_receiver host_u (.terminals_in(term), .terminals_oe_in(oe), .event_seen_out(ev));

    task automatic check(string name, logic [31:0] exp, logic [31:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic end_sim;
        check("pending reads", 32'h0, exp_q.size());
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic tick(int n);
        repeat (n) @(posedge clk_in);
        #2;
    endtask : tick

    // One config request; its read data is noted for the monitor
    task automatic cfg(logic wr, logic fn, logic [5:0] adr, logic [3:0] be, logic [31:0] wd, logic [31:0] exp);
        tick(1);
        req = {1'b1, wr, fn, adr, be, wd};
        exp_q.push_back(exp);
        tick(1);
        req.valid = 1'b0;
    endtask : cfg

    task automatic rd_ev(logic [15:0] st);
        cfg(1'b0, 1'b0, 6'h2A, 4'hF, '0, {en_m, st});
    endtask : rd_ev

    // Raise one event source; m is the status it should leave
    task automatic fire(int k, output logic [15:0] m);
        tick(1);
        case (k)
            0: begin vid[0] = ~vid[0]; m = 16'h8000; end
            1: begin vid[1] = ~vid[1]; m = 16'h4000; end
            2: begin pw1.vcc_req = pw1.vcc_req + 2'h1; m = 16'h0800; end
            3: begin pw0.vpp_req = (pw0.vpp_req == VPP_12V_CODE) ? 2'h1 : VPP_12V_CODE; m = 16'h0900; end
            default: begin gin[k-4] = ~gin[k-4]; m = 16'h0001 << (k - 4); end
        endcase
        tick(8);
    endtask : fire

    // Answer monitor: each ack takes the oldest note
    always @(posedge clk_in) begin
        if (ack === 1'b1) begin
            check("cfg_rdata_out", exp_q.size() ? exp_q.pop_front() : 32'hDEAD, rdata);
        end
    end

    // Hang guard, well beyond the expected run
    initial begin
        #(40000 * 25);
        errors++;
        end_sim;
    end

    initial begin
        logic [15:0] m;
        logic [15:0] r;
        repeat (8) @(posedge clk_in);
        #2;
        rst_b_in = 1'b1;
        tick(4);
        cfg(1'b0, 1'b0, 6'h29, 4'hF, '0, '0);
        cfg(1'b1, 1'b1, 6'h29, 4'hF, '1, '0);
        cfg(1'b0, 1'b1, 6'h29, 4'hF, '0, '0);
        cfg(1'b1, 1'b1, 6'h2A, 4'hF, '1, '0);
        rd_ev(16'h0);
        r = 16'($random(seed));
        cfg(1'b1, 1'b0, 6'h2A, 4'hC, {r, 16'hFFFF}, '0);
        en_m = r & EVENT_BITS_MASK;
        rd_ev(16'h0);
        cfg(1'b1, 1'b0, 6'h2A, 4'hC, '0, '0);
        en_m = '0;
        $display("test reset and access done");
        // Sources with enables off; write 0 keeps, write 1 clears
        for (int k = 0; k < 9; k++) begin
            fire(k, m);
            rd_ev(m);
            check("event_status_out", {16'h0, m}, {16'h0, sts});
            check("event idle", 32'h0, 32'(ev));
            cfg(1'b1, 1'b0, 6'h2A, 4'h3, {16'h0, ~m}, '0);
            rd_ev(m);
            cfg(1'b1, 1'b0, 6'h2A, 4'h3, {16'h0, m}, '0);
            rd_ev(16'h0);
        end
        $display("test status done");
        cfg(1'b1, 1'b0, 6'h2A, 4'hC, '1, '0);
        en_m = EVENT_BITS_MASK;
        rd_ev(16'h0);
        for (int k = 0; k < 9; k++) begin
            fire(k, m);
            check("event raised", 32'h1, 32'(ev));
            cfg(1'b1, 1'b0, 6'h2A, 4'h3, {16'h0, ~m}, '0);
            tick(3);
            check("event held", 32'h1, 32'(ev));
            cfg(1'b1, 1'b0, 6'h2A, 4'h3, {16'h0, m}, '0);
            tick(2);
            check("event dropped", 32'h0, 32'(ev));
        end
        $display("test enable done");
        mode = '0;
        fire(8, m);
        check("mode gate", 32'h0, 32'(ev));
        rd_ev(m);
        mode = '1;
        route = 7'h00;
        tick(3);
        check("unrouted", 32'h0, {31'h0, ev});
        check("unrouted oe", 32'h0, 32'(oe));
        check("unrouted level", 32'h7F, 32'(term));
        route = 7'h41;
        tick(3);
        check("terminal 6", 32'h0, 32'(term[6]));
        check("routed oe", 32'h41, 32'(oe));
        cfg(1'b1, 1'b0, 6'h2A, 4'h3, {16'h0, m}, '0);
        tick(2);
        check("event dropped", 32'h0, 32'(ev));
        $display("test gating done");
        tick(4);
        end_sim;
    end
endmodule : general_purpose_event_logic_tb_top

bind general_purpose_event_logic gen_event_asserts asserts_u (.clk_in, .rst_b_in, .cfg_req_in, .cfg_ack_out,
    .cfg_rdata_out, .video_port_on_flag_in, .socket0_power_in, .socket1_power_in, .general_input_in,
    .multipurpose_terminals_out, .multipurpose_terminals_oe_out, .event_status_out);
`default_nettype wire
